// ===== design/sbtfe_pkg.sv
package sbtfe_pkg;

  // Flow geometry
  localparam int SBTFE_NSTATE = 4;
  localparam int SBTFE_NBR    = 3;
  localparam int SBTFE_NSLOT  = 4;
  localparam int SBTFE_NTAB   = SBTFE_NSTATE * SBTFE_NSLOT;
  localparam int SBTFE_NCNT   = 2;
  localparam int SBTFE_NFLAG  = 2;
  localparam int SBTFE_CNT_W  = 16;
  localparam int SBTFE_SMP_W  = 8;
  localparam int SBTFE_COND_W = 4;
  localparam int SBTFE_PF_W   = 6;
  localparam int SBTFE_AW     = 6;
  localparam int SBTFE_DEPTH  = 64;
  localparam int SBTFE_SEG_AW = 4;

  // Sample depths used for the reported trigger position
  localparam logic [6:0] SBTFE_BUF_N = 7'h40;
  localparam logic [6:0] SBTFE_SEG_N = 7'h10;

  // Register byte offsets
  localparam logic [7:0] SBTFE_REG_CTRL    = 8'h00;
  localparam logic [7:0] SBTFE_REG_STATUS  = 8'h04;
  localparam logic [7:0] SBTFE_REG_CNT     = 8'h08;
  localparam logic [7:0] SBTFE_REG_DEFPOS  = 8'h0c;
  localparam logic [7:0] SBTFE_REG_TRIGPOS = 8'h10;
  localparam logic [7:0] SBTFE_REG_RDADDR  = 8'h14;
  localparam logic [7:0] SBTFE_REG_RDDATA  = 8'h18;
  localparam logic [7:0] SBTFE_REG_TAB     = 8'h40;

  // Control field positions
  localparam int SBTFE_CTRL_START = 0;
  localparam int SBTFE_CTRL_STOP  = 1;
  localparam int SBTFE_CTRL_SEG   = 2;
  localparam int SBTFE_CTRL_QUAL  = 3;

  // Default post-fill field positions
  localparam int SBTFE_DEF_BUF_LSB = 0;
  localparam int SBTFE_DEF_SEG_LSB = 8;

  // Reset values
  localparam logic [31:0] SBTFE_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SBTFE_DEFPOS_RST = 32'h0000_0820;
  localparam logic [31:0] SBTFE_CNT_RST    = 32'h0000_0000;

  typedef struct packed {
    logic [8:0] rsvd;
    logic       pf_use;
    logic [5:0] pf_cnt;
    logic       clr_flag;
    logic       set_flag;
    logic       stop_store;
    logic       start_store;
    logic [1:0] goto_dst;
    logic       do_goto;
    logic       seg_trig;
    logic       trig;
    logic       res_idx;
    logic       dec;
    logic       inc;
    logic       cond_always;
    logic [1:0] cond_sel;
    logic       enable;
  } sbtfe_branch_t;

  typedef enum logic [1:0] {
    SBTFE_IDLE = 2'b00,
    SBTFE_ACQ  = 2'b01,
    SBTFE_POST = 2'b10,
    SBTFE_DONE = 2'b11
  } sbtfe_phase_t;

  function automatic logic [31:0] sbtfe_merge(input logic [31:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : sbtfe_merge

endpackage : sbtfe_pkg

// ===== design/sbtfe_engine.sv
// Behaviour
// - Step-up action adds exactly one to the chosen counter.
// - Step-down action subtracts exactly one from the chosen counter.
// - Final trigger stops acquisition into the buffer and ends the run.
// - Segment close finishes current segment and continues in the next one.
// - With all segments filled, the oldest segment is overwritten.
// - Segmented capture cycles segments until a final trigger stops it.
// - A given post-fill count captures that many samples then stops.
// - Without post-fill count the preset default position is used.
// - Trigger after pending segment close cuts it, marking rest invalid.
// - Jump makes the named state active for the next sample.
// - With qualification on, nothing is stored before a store start; in segmented mode the code ignores qualification and stores from the run start.
// - Store start/stop keep acting after the final trigger.
// - Writes suspended during post-fill leave the run paused, incomplete.
// - Host manual stop ends the run as triggered and complete.
// - Counters, flags and active state are readable live.
// - Store start/stop act on the very sample of their cycle.
// - Branches are tried in order; first true branch wins.
// - All actions of the chosen branch act in the same cycle.
// - Reported trigger position is depth minus post-fill count.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sbtfe_engine
  import sbtfe_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [SBTFE_SMP_W-1:0]  sample_in,
  input  wire logic [SBTFE_COND_W-1:0] cond_in,
  output logic                         acq_running,
  output logic                         acq_triggered,
  output logic                         acq_complete
);

  // Registers
  logic [31:0]          ctrl;
  logic [31:0]          defpos;
  logic [31:0]          cnt_init;
  logic [SBTFE_AW-1:0]  rd_addr;
  sbtfe_branch_t        tab [SBTFE_NTAB];

  // Engine state
  sbtfe_phase_t         phase;
  logic [1:0]           active;
  logic [SBTFE_CNT_W-1:0] cnt [SBTFE_NCNT];
  logic [SBTFE_NFLAG-1:0] flags;
  logic                 store_on;
  logic [SBTFE_PF_W-1:0] pf_left;
  logic                 pf_seg;
  logic [SBTFE_AW-1:0]  wptr;
  logic                 triggered;
  logic [6:0]           trig_pos;
  logic [3:0]           seg_cut;
  logic [SBTFE_SEG_AW-1:0] seg_stop [4];
  logic [SBTFE_DEPTH-1:0] vbit;
  logic [SBTFE_SMP_W-1:0] mem [SBTFE_DEPTH];

  // Bus decode
  wire       bus_req   = wb_cyc_i & wb_stb_i;
  wire       bus_wr    = bus_req & wb_we_i & wb_ack_o;
  wire       hit_ctrl  = wb_adr_i == SBTFE_REG_CTRL;
  wire       hit_cnt   = wb_adr_i == SBTFE_REG_CNT;
  wire       hit_def   = wb_adr_i == SBTFE_REG_DEFPOS;
  wire       hit_rda   = wb_adr_i == SBTFE_REG_RDADDR;
  wire       hit_tab   = (wb_adr_i[7:6] == SBTFE_REG_TAB[7:6])
                         & (wb_adr_i[3:2] != 2'h3);
  wire [3:0] tab_idx   = wb_adr_i[5:2];
  wire       start_p   = bus_wr & hit_ctrl & wb_sel_i[0]
                         & wb_dat_i[SBTFE_CTRL_START];
  wire       stop_p    = bus_wr & hit_ctrl & wb_sel_i[0]
                         & wb_dat_i[SBTFE_CTRL_STOP];
  wire       seg_mode  = ctrl[SBTFE_CTRL_SEG];
  wire       qual_en   = ctrl[SBTFE_CTRL_QUAL] & ~seg_mode;
  wire [1:0] seg       = wptr[5:4];
  wire [3:0] seg_off   = wptr[3:0];
  // Segment number is only meaningful in segmented mode
  wire [1:0] seg_rep   = seg_mode ? seg : 2'h0;
  wire [SBTFE_PF_W-1:0] def_buf = defpos[SBTFE_DEF_BUF_LSB +: SBTFE_PF_W];
  wire [SBTFE_PF_W-1:0] def_seg = defpos[SBTFE_DEF_SEG_LSB +: SBTFE_PF_W];

  // Branch evaluation for the active state
  logic [SBTFE_NBR-1:0] cond_true;
  sbtfe_branch_t        br [SBTFE_NBR];
  genvar gb;
  generate
    for (gb = 0; gb < SBTFE_NBR; gb++) begin : g_br
      assign br[gb] = tab[{active, 2'(gb)}];
      assign cond_true[gb] = br[gb].enable
                             & (br[gb].cond_always | cond_in[br[gb].cond_sel]);
    end
  endgenerate

  sbtfe_branch_t act;
  always_comb begin
    act = '0;
    for (int b = SBTFE_NBR - 1; b >= 0; b--) begin
      if (cond_true[b]) begin
        act = br[b];
      end
    end
  end

  // Action decode
  wire live     = (phase == SBTFE_ACQ) | (phase == SBTFE_POST);
  wire fire     = act.trig | (act.seg_trig & seg_mode);
  wire abort    = (phase == SBTFE_POST) & pf_seg & fire;
  wire end_now  = (phase == SBTFE_POST) & (pf_left == '0);
  wire store_eff = ~qual_en
                   | act.start_store | (store_on & ~act.stop_store);
  wire wr_en    = live & store_eff & ~abort & ~end_now;
  wire [SBTFE_PF_W-1:0] pf_sel = act.pf_use ? act.pf_cnt
                                 : (seg_mode ? def_seg : def_buf);
  wire [6:0] pos_n = seg_mode ? SBTFE_SEG_N : SBTFE_BUF_N;
  wire [SBTFE_AW-1:0] wptr_inc = seg_mode ? {seg, seg_off + 4'h1}
                                 : wptr + 6'h01;
  wire [SBTFE_AW-1:0] wptr_nseg = {seg + 2'h1, 4'h0};

  // Next engine state
  sbtfe_phase_t         next_phase;
  logic [1:0]           next_active;
  logic [SBTFE_CNT_W-1:0] next_cnt [SBTFE_NCNT];
  logic [SBTFE_NFLAG-1:0] next_flags;
  logic                 next_store_on;
  logic [SBTFE_PF_W-1:0] next_pf_left;
  logic                 next_pf_seg;
  logic [SBTFE_AW-1:0]  next_wptr;
  logic                 next_triggered;
  logic [6:0]           next_trig_pos;
  logic                 seg_enter;
  logic                 seg_cut_now;

  always_comb begin
    next_phase     = phase;
    next_active    = active;
    next_cnt       = cnt;
    next_flags     = flags;
    next_store_on  = store_on;
    next_pf_left   = pf_left;
    next_pf_seg    = pf_seg;
    next_wptr      = wptr;
    next_triggered = triggered;
    next_trig_pos  = trig_pos;
    seg_enter      = 1'b0;
    seg_cut_now    = 1'b0;
    case (phase)
      SBTFE_ACQ, SBTFE_POST: begin
        // Actions of the chosen branch act together
        for (int i = 0; i < SBTFE_NCNT; i++) begin
          if (act.inc && act.res_idx == 1'(i)) begin
            next_cnt[i] = next_cnt[i] + 16'h0001;
          end
          if (act.dec && act.res_idx == 1'(i)) begin
            next_cnt[i] = next_cnt[i] - 16'h0001;
          end
        end
        if (act.set_flag) begin
          next_flags[act.res_idx] = 1'b1;
        end
        if (act.clr_flag) begin
          next_flags[act.res_idx] = 1'b0;
        end
        if (act.do_goto) begin
          next_active = act.goto_dst;
        end
        if (qual_en) begin
          next_store_on = store_eff;
        end
        if (abort) begin
          seg_cut_now = 1'b1;
          seg_enter   = 1'b1;
          next_wptr   = wptr_nseg;
        end else if (wr_en) begin
          next_wptr = wptr_inc;
        end
        if (phase == SBTFE_POST && !abort) begin
          if (end_now || (wr_en && pf_left == 6'h01)) begin
            if (pf_seg) begin
              seg_enter  = 1'b1;
              next_wptr  = wptr_nseg;
              next_phase = SBTFE_ACQ;
            end else begin
              next_phase = SBTFE_DONE;
            end
          end else if (wr_en) begin
            next_pf_left = pf_left - 6'h01;
          end
        end
        if (fire && (phase == SBTFE_ACQ || abort)) begin
          next_phase     = SBTFE_POST;
          next_pf_left   = pf_sel;
          next_pf_seg    = ~act.trig;
          next_triggered = triggered | act.trig;
          next_trig_pos  = pos_n - {1'b0, pf_sel};
        end
      end
      SBTFE_IDLE, SBTFE_DONE: begin
      end
      default: begin
        next_phase = SBTFE_IDLE;
      end
    endcase
    if (stop_p && phase != SBTFE_IDLE) begin
      next_phase     = SBTFE_DONE;
      next_triggered = 1'b1;
    end
  end

  // Bus slave: ack one cycle after the request, writes at the ack edge
  wire rd_valid = vbit[rd_addr]
                  & ~(seg_mode & seg_cut[rd_addr[5:4]]
                      & (rd_addr[3:0] >= seg_stop[rd_addr[5:4]]));
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = {28'h0, ctrl[3:2], 2'h0};
    end else if (wb_adr_i == SBTFE_REG_STATUS) begin
      rd_mux = {22'h0, flags, seg_rep, active,
                live & triggered & qual_en & ~store_on,
                phase == SBTFE_DONE, triggered, live};
    end else if (hit_cnt) begin
      rd_mux = {cnt[1], cnt[0]};
    end else if (hit_def) begin
      rd_mux = defpos;
    end else if (wb_adr_i == SBTFE_REG_TRIGPOS) begin
      rd_mux = {25'h0, trig_pos};
    end else if (hit_rda) begin
      rd_mux = {26'h0, rd_addr};
    end else if (wb_adr_i == SBTFE_REG_RDDATA) begin
      rd_mux = {23'h0, rd_valid, mem[rd_addr]};
    end else if (hit_tab) begin
      rd_mux = tab[tab_idx];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl     <= SBTFE_CTRL_RST;
      defpos   <= SBTFE_DEFPOS_RST;
      cnt_init <= SBTFE_CNT_RST;
      rd_addr  <= '0;
      for (int i = 0; i < SBTFE_NTAB; i++) begin
        tab[i] <= '0;
      end
    end else if (bus_wr) begin
      if (hit_ctrl) begin
        ctrl <= sbtfe_merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_000c;
      end
      if (hit_def) begin
        defpos <= sbtfe_merge(defpos, wb_dat_i, wb_sel_i) & 32'h0000_3f3f;
      end
      if (hit_cnt) begin
        cnt_init <= sbtfe_merge(cnt_init, wb_dat_i, wb_sel_i);
      end
      if (hit_rda && wb_sel_i[0]) begin
        rd_addr <= wb_dat_i[SBTFE_AW-1:0];
      end
      if (hit_tab) begin
        tab[tab_idx] <= sbtfe_merge(tab[tab_idx], wb_dat_i, wb_sel_i);
      end
    end
  end

  // Engine registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase     <= SBTFE_IDLE;
      active    <= 2'h0;
      flags     <= '0;
      store_on  <= 1'b0;
      pf_left   <= '0;
      pf_seg    <= 1'b0;
      wptr      <= '0;
      triggered <= 1'b0;
      trig_pos  <= 7'h00;
      for (int i = 0; i < SBTFE_NCNT; i++) begin
        cnt[i] <= '0;
      end
    end else if (start_p) begin
      phase     <= SBTFE_ACQ;
      active    <= 2'h0;
      flags     <= '0;
      store_on  <= 1'b0;
      pf_left   <= '0;
      pf_seg    <= 1'b0;
      wptr      <= '0;
      triggered <= 1'b0;
      trig_pos  <= 7'h00;
      cnt[0]    <= cnt_init[15:0];
      cnt[1]    <= cnt_init[31:16];
    end else begin
      phase     <= next_phase;
      active    <= next_active;
      flags     <= next_flags;
      store_on  <= next_store_on;
      pf_left   <= next_pf_left;
      pf_seg    <= next_pf_seg;
      wptr      <= next_wptr;
      triggered <= next_triggered;
      trig_pos  <= next_trig_pos;
      cnt       <= next_cnt;
    end
  end

  // Sample memory, valid bits and segment cut marks
  always_ff @(posedge ref_clk) begin
    if (reset || start_p) begin
      vbit    <= '0;
      seg_cut <= 4'h0;
      for (int s = 0; s < 4; s++) begin
        seg_stop[s] <= 4'h0;
      end
    end else begin
      if (wr_en) begin
        vbit[wptr] <= 1'b1;
      end
      if (seg_cut_now) begin
        seg_cut[seg]  <= 1'b1;
        seg_stop[seg] <= seg_off;
      end
      if (seg_enter) begin
        seg_cut[next_wptr[5:4]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wptr] <= sample_in;
    end
  end

  assign acq_running   = live;
  assign acq_triggered = triggered;
  assign acq_complete  = phase == SBTFE_DONE;

endmodule : sbtfe_engine

// ===== verification/sbtfe_properties.sv
`timescale 1ns/1ps
module sbtfe_properties
  import sbtfe_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        acq_running,
  input wire logic        acq_triggered,
  input wire logic        acq_complete
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence ctrl_wr;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == SBTFE_REG_CTRL;
  endsequence
  sequence stop_wr;
    ctrl_wr ##0 (wb_dat_i[SBTFE_CTRL_STOP] && !wb_dat_i[SBTFE_CTRL_START]);
  endsequence
  sequence start_wr;
    ctrl_wr ##0 (wb_dat_i[SBTFE_CTRL_START] && !wb_dat_i[SBTFE_CTRL_STOP]);
  endsequence

  ack_latency_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus answer not one cycle after request");
  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus answer longer than one cycle");
  stop_done_a: assert property (
    stop_wr ##0 acq_running |-> ##[1:2] (acq_complete && acq_triggered))
    else $error("Manual stop did not complete the run");
  start_run_a: assert property (
    start_wr |-> ##[1:2] (acq_running && !acq_triggered && !acq_complete))
    else $error("Start did not launch a fresh run");
  done_idle_a: assert property (
    acq_complete |-> !acq_running)
    else $error("Completed run still acquiring");
  done_holds_a: assert property (
    acq_complete && !wb_ack_o |=> acq_complete)
    else $error("Completed run left done without a start");
  done_trig_a: assert property (
    $rose(acq_complete) |-> acq_triggered)
    else $error("Run completed without a trigger");
  trig_run_a: assert property (
    $rose(acq_triggered) |-> $past(acq_running))
    else $error("Trigger seen while not acquiring");
endmodule : sbtfe_properties

bind sbtfe_engine sbtfe_properties u_props (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .acq_running(acq_running), .acq_triggered(acq_triggered),
  .acq_complete(acq_complete)
);

// ===== verification/sbtfe_user_model.sv
`timescale 1ns/1ps
module sbtfe_user_model
  import sbtfe_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic [SBTFE_COND_W-1:0] cond_req,
  output logic      [SBTFE_SMP_W-1:0]  sample_in,
  output logic      [SBTFE_COND_W-1:0] cond_in
);
  logic [SBTFE_SMP_W-1:0] cnt = '0;

  // User data changes every sample
  always @(posedge ref_clk) begin
    cnt <= cnt + 1'b1;
  end
  assign sample_in = cnt ^ 8'h5a;
  assign cond_in   = cond_req;
endmodule : sbtfe_user_model

// ===== verification/sbtfe_engine_tb.sv
`timescale 1ns/1ps
module sbtfe_engine_tb;
  import sbtfe_pkg::*;
  logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, sample_in;
  logic [3:0]  wb_sel_i, cond_req, cond_in;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        acq_running, acq_triggered, acq_complete;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  sbtfe_user_model um (.ref_clk(ref_clk), .cond_req(cond_req),
    .sample_in(sample_in), .cond_in(cond_in));

  sbtfe_engine uut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_in(sample_in), .cond_in(cond_in),
    .acq_running(acq_running), .acq_triggered(acq_triggered),
    .acq_complete(acq_complete));

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // Condition held for exactly n sampling edges
  task automatic drive(input logic [3:0] c, input int n);
    @(posedge ref_clk);
    cond_req <= c;
    repeat (n) @(posedge ref_clk);
    cond_req <= 4'h0;
  endtask : drive

  task automatic flow(input logic [31:0] b0, b1, b2);
    wr(8'h40, b0);
    wr(8'h44, b1);
    wr(8'h48, b2);
  endtask : flow

  task automatic t_regs;
    rchk(SBTFE_REG_CTRL, SBTFE_CTRL_RST);
    rchk(SBTFE_REG_DEFPOS, SBTFE_DEFPOS_RST);
    rchk(SBTFE_REG_CNT, SBTFE_CNT_RST);
    wr(SBTFE_REG_STATUS, 32'hffff_ffff);
    rchk(SBTFE_REG_STATUS, 32'h0);
    wr(8'h4c, 32'hffff_ffff);
    rchk(8'h4c, 32'h0);
    wr(SBTFE_REG_CTRL, 32'hc);
    rchk(SBTFE_REG_CTRL, 32'hc);
    wr(SBTFE_REG_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_count;
    wr(SBTFE_REG_CNT, 32'h0005_0010);
    flow(32'h0000_4011, 32'h0000_0023, 32'h0000_0a07);
    wr(8'h60, 32'h0000_0085);
    wr(SBTFE_REG_CTRL, 32'h1);
    idle(2);
    drive(4'h1, 3);
    drive(4'h3, 2);
    drive(4'h2, 4);
    drive(4'h8, 1);
    rchk(SBTFE_REG_CNT, 32'h0005_0011);
    rchk(SBTFE_REG_STATUS, 32'h0000_0121);
    wr(SBTFE_REG_CTRL, 32'h2);
    idle(2);
    chk1(acq_complete, 1'b1);
  endtask : t_count

  task automatic t_trig;
    flow(32'h0042_0081, 32'h0, 32'h0);
    wr(SBTFE_REG_CTRL, 32'h1);
    idle(2);
    drive(4'h1, 1);
    idle(1);
    #1 chk1(acq_complete, 1'b0);
    idle(1);
    #1 chk1(acq_complete, 1'b1);
    chk1(acq_triggered, 1'b1);
    rchk(SBTFE_REG_TRIGPOS, 32'h3e);
    wr(SBTFE_REG_DEFPOS, 32'h0000_0805);
    flow(32'h0000_0081, 32'h0, 32'h0);
    wr(SBTFE_REG_CTRL, 32'h1);
    idle(2);
    drive(4'h1, 1);
    for (int i = 0; i < 40 && acq_complete !== 1'b1; i++) idle(1);
    chk1(acq_complete, 1'b1);
    rchk(SBTFE_REG_TRIGPOS, 32'h3b);
  endtask : t_trig

  // Store on, trigger with three left, one write, then stop store
  task automatic qual_pause;
    wr(SBTFE_REG_CTRL, 32'h9);
    idle(2);
    drive(4'h1, 1);
    drive(4'h2, 1);
    drive(4'h4, 1);
    idle(8);
    rchk(SBTFE_REG_STATUS, 32'h0000_000b);
    chk1(acq_running, 1'b1);
  endtask : qual_pause

  task automatic t_qual;
    flow(32'h0000_1001, 32'h0043_0083, 32'h0000_2005);
    qual_pause();
    wr(SBTFE_REG_CTRL, 32'ha);
    idle(2);
    chk1(acq_complete, 1'b1);
    chk1(acq_triggered, 1'b1);
    qual_pause();
    drive(4'h1, 1);
    #1 chk1(acq_complete, 1'b0);
    idle(1);
    #1 chk1(acq_complete, 1'b1);
  endtask : t_qual

  task automatic t_seg;
    flow(32'h0044_0101, 32'h0040_0083, 32'h0);
    wr(SBTFE_REG_CTRL, 32'h5);
    idle(2);
    for (int i = 0; i < 5; i++) begin
      drive(4'h1, 1);
      idle(8);
    end
    rchk(SBTFE_REG_STATUS, 32'h0000_0041);
    drive(4'h1, 1);
    drive(4'h2, 1);
    idle(3);
    rchk(SBTFE_REG_STATUS, 32'h0000_0086);
  endtask : t_seg

  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cond_req = 4'h0;
    idle(3);
    reset <= 1'b0;
    t_regs();
    t_count();
    t_trig();
    t_qual();
    t_seg();
    give_verdict();
  end
endmodule : sbtfe_engine_tb
